// *** src/bst_pkg.sv ***
// Shared constants for the boundary-scan test access port.
// Assumes one system clock samples every test-port pin.
package bst_pkg;

    // Instruction register
    localparam int unsigned IR_W = 5;
    localparam logic [IR_W-1:0] IR_EXTEST  = 5'h00;
    localparam logic [IR_W-1:0] IR_SAMPLE  = 5'h01;
    localparam logic [IR_W-1:0] IR_CLAMP   = 5'h04;
    localparam logic [IR_W-1:0] IR_HIGHZ   = 5'h05;
    localparam logic [IR_W-1:0] IR_IDCODE  = 5'h0C;
    localparam logic [IR_W-1:0] IR_BYPASS  = 5'h1F;
    localparam logic [IR_W-1:0] IR_CAPTURE = 5'h01;

    // Identification register layout
    localparam int unsigned ID_W       = 32;
    localparam int unsigned ID_VER_LSB = 28;
    localparam int unsigned ID_PRT_LSB = 12;
    localparam int unsigned ID_MFR_LSB = 1;
    // Arbitrary identity values, not those of any real part
    localparam logic [3:0]  ID_VERSION = 4'h3;
    localparam logic [15:0] ID_PART    = 16'h0A5A;
    localparam logic [10:0] ID_MFR     = 11'h155;
    localparam logic        ID_FIXED   = 1'b1;
    localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MFR, ID_FIXED};

    // Pin population: four cell kinds
    localparam int unsigned N_IN   = 2;
    localparam int unsigned N_OUT  = 2;
    localparam int unsigned N_BI   = 2;
    localparam int unsigned N_PIN_IN  = N_IN + N_BI;
    localparam int unsigned N_PIN_OUT = N_OUT + N_BI;
    localparam int unsigned CH_IN_LO  = 0;
    localparam int unsigned CH_OUT_LO = N_IN;
    localparam int unsigned CH_BI_LO  = N_IN + N_OUT;
    localparam int unsigned CH_CTL_LO = N_IN + N_OUT + N_BI;
    localparam int unsigned CH_LEN    = N_IN + N_OUT + 2 * N_BI;

    typedef enum logic [3:0] {
        ST_TLR    = 4'h0,
        ST_RTI    = 4'h1,
        ST_SEL_DR = 4'h3,
        ST_CAP_DR = 4'h2,
        ST_SH_DR  = 4'h6,
        ST_EX1_DR = 4'h7,
        ST_PA_DR  = 4'h5,
        ST_EX2_DR = 4'h4,
        ST_UPD_DR = 4'hC,
        ST_SEL_IR = 4'hD,
        ST_CAP_IR = 4'hF,
        ST_SH_IR  = 4'hE,
        ST_EX1_IR = 4'hA,
        ST_PA_IR  = 4'hB,
        ST_EX2_IR = 4'h9,
        ST_UPD_IR = 4'h8
    } bst_state_t;

    typedef enum logic [2:0] {
        MD_EXTEST = 3'h0,
        MD_SAMPLE = 3'h1,
        MD_HIGHZ  = 3'h2,
        MD_CLAMP  = 3'h3,
        MD_IDCODE = 3'h4,
        MD_BYPASS = 3'h5
    } bst_mode_t;

endpackage

// *** src/bst_bscan_chain.sv ***
// Boundary-scan register: capture/shift stage plus update latch.
// Assumes strobes arrive as one-cycle pulses from the port controller.
`timescale 1ns/1ns
`default_nettype none
module bst_bscan_chain (
    input  wire logic                       mclk_i,
    input  wire logic                       srst_i,
    input  wire logic                       ce_i,
    input  wire logic                       capture_i,
    input  wire logic                       shift_i,
    input  wire logic                       update_i,
    input  wire logic                       tdi_i,
    input  wire logic [bst_pkg::CH_LEN-1:0] par_i,
    output logic                            so_o,
    output logic [bst_pkg::CH_LEN-1:0]      upd_o
);
    typedef struct packed {
        logic [bst_pkg::CH_LEN-1:0] sh;
        logic [bst_pkg::CH_LEN-1:0] upd;
    } bst_chain_t;

    bst_chain_t q, d;

    always_comb begin
        d = q;
        if (capture_i) begin
            d.sh = par_i;
        end else if (shift_i) begin
            d.sh = {tdi_i, q.sh[bst_pkg::CH_LEN-1:1]};
        end
        if (update_i) begin
            d.upd = q.sh;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign so_o  = q.sh[0];
    assign upd_o = q.upd;
endmodule // bst_bscan_chain
`default_nettype wire

// *** src/bst_tap.sv ***
// Boundary-scan test access port: controller, instruction, bypass,
// identification and pin multiplexing. Test pins and pads are
// asynchronous and are synchronised to mclk_i before use.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Sixteen-state controller advanced by test clock, steered by mode select.
// - System reset puts controller in Test-Logic-Reset independent of functional logic.
// - Five-bit instruction register picks data register and operation.
// - Undefined instruction codes behave as bypass.
// - Code 00000 selects boundary register, pins driven from it.
// - Code 00001 selects boundary register, samples pins, preloads, pins untouched.
// - Code 00101 selects bypass, all output pins released.
// - Code 00100 drives pins from boundary register, bypass is shift path.
// - Code 01100 selects identification register.
// - One-bit bypass register is shortest path for bypass instructions.
// - Identification holds version, part, maker fields in fixed positions.
// - Identification bit zero always reads one.
// - Boundary register is a serial chain from data in to data out.
// - Chain covers every functional input, output and bidirectional pin.
// - Four cell kinds: input, output, bidirectional, output-enable control.
// - Boundary cells are test-only logic with no system function.
// - Sample and extest load the cells in parallel on rising test clock.
module bst_tap (
    input  wire logic                          mclk_i,
    input  wire logic                          srst_i,
    input  wire logic                          ce_i,
    input  wire logic                          tck_i,
    input  wire logic                          tms_i,
    input  wire logic                          tdi_i,
    input  wire logic                          trst_n_i,
    output logic                               tdo_o,
    output logic                               tdo_oe_o,
    input  wire logic [bst_pkg::N_PIN_IN-1:0]  pad_in_i,
    output logic [bst_pkg::N_PIN_OUT-1:0]      pad_out_o,
    output logic [bst_pkg::N_PIN_OUT-1:0]      pad_oe_o,
    input  wire logic [bst_pkg::N_PIN_OUT-1:0] core_out_i,
    input  wire logic [bst_pkg::N_BI-1:0]      core_oe_i,
    output logic [bst_pkg::N_PIN_IN-1:0]       core_in_o,
    output logic [bst_pkg::IR_W-1:0]           ir_o
);
    typedef struct packed {
        logic                          tck_s1;
        logic                          tck_s2;
        logic                          tck_s3;
        logic                          tms_s1;
        logic                          tms_s2;
        logic                          tdi_s1;
        logic                          tdi_s2;
        logic                          trst_n_s1;
        logic                          trst_n_s2;
        logic [bst_pkg::N_PIN_IN-1:0]  pad_s1;
        logic [bst_pkg::N_PIN_IN-1:0]  pad_s2;
        bst_pkg::bst_state_t           state;
        logic [bst_pkg::IR_W-1:0]      ir_sh;
        logic [bst_pkg::IR_W-1:0]      ir;
        logic                          byp;
        logic [bst_pkg::ID_W-1:0]      id_sh;
        logic                          tdo;
        logic                          tdo_oe;
        logic [bst_pkg::N_PIN_OUT-1:0] pad_out;
        logic [bst_pkg::N_PIN_OUT-1:0] pad_oe;
        logic [bst_pkg::N_PIN_IN-1:0]  core_in;
    } bst_tap_t;

    bst_tap_t q, d;

    function automatic bst_pkg::bst_state_t next_state(input bst_pkg::bst_state_t s, input logic tms);
        bst_pkg::bst_state_t n;
        n = s;
        unique case (s)
            bst_pkg::ST_TLR:    n = tms ? bst_pkg::ST_TLR    : bst_pkg::ST_RTI;
            bst_pkg::ST_RTI:    n = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
            bst_pkg::ST_SEL_DR: n = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
            bst_pkg::ST_CAP_DR: n = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_SH_DR:  n = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_EX1_DR: n = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PA_DR;
            bst_pkg::ST_PA_DR:  n = tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PA_DR;
            bst_pkg::ST_EX2_DR: n = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_UPD_DR: n = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
            bst_pkg::ST_SEL_IR: n = tms ? bst_pkg::ST_TLR    : bst_pkg::ST_CAP_IR;
            bst_pkg::ST_CAP_IR: n = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_SH_IR:  n = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_EX1_IR: n = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PA_IR;
            bst_pkg::ST_PA_IR:  n = tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR;
            bst_pkg::ST_EX2_IR: n = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_UPD_IR: n = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
        endcase
        return n;
    endfunction

    // Codes outside the defined set, including the private ones, fall to bypass
    function automatic bst_pkg::bst_mode_t ir_decode(input logic [bst_pkg::IR_W-1:0] ir);
        bst_pkg::bst_mode_t m;
        m = bst_pkg::MD_BYPASS;
        unique case (ir)
            bst_pkg::IR_EXTEST: m = bst_pkg::MD_EXTEST;
            bst_pkg::IR_SAMPLE: m = bst_pkg::MD_SAMPLE;
            bst_pkg::IR_HIGHZ:  m = bst_pkg::MD_HIGHZ;
            bst_pkg::IR_CLAMP:  m = bst_pkg::MD_CLAMP;
            bst_pkg::IR_IDCODE: m = bst_pkg::MD_IDCODE;
            default:            m = bst_pkg::MD_BYPASS;
        endcase
        return m;
    endfunction

    logic                       tck_rise;
    logic                       tck_fall;
    bst_pkg::bst_mode_t         mode;
    logic                       sel_bscan;
    logic                       pins_from_chain;
    logic                       in_shift;
    logic                       ch_so;
    logic [bst_pkg::CH_LEN-1:0] ch_upd;
    logic [bst_pkg::CH_LEN-1:0] ch_par;

    assign tck_rise        = q.tck_s2 & ~q.tck_s3;
    assign tck_fall        = ~q.tck_s2 & q.tck_s3;
    assign mode            = ir_decode(q.ir);
    assign sel_bscan       = (mode == bst_pkg::MD_EXTEST) || (mode == bst_pkg::MD_SAMPLE);
    assign pins_from_chain = (mode == bst_pkg::MD_EXTEST) || (mode == bst_pkg::MD_CLAMP);
    assign in_shift        = (q.state == bst_pkg::ST_SH_DR) || (q.state == bst_pkg::ST_SH_IR);

    // Inputs and bidir data capture the pin, outputs the core driver, controls the core enable
    assign ch_par = {core_oe_i,
                     q.pad_s2[bst_pkg::N_PIN_IN-1:bst_pkg::N_IN],
                     core_out_i[bst_pkg::N_OUT-1:0],
                     q.pad_s2[bst_pkg::N_IN-1:0]};

    // Test-only cells; the functional path never passes through them
    bst_bscan_chain u_chain (
        .mclk_i    (mclk_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .capture_i (tck_rise && sel_bscan && q.state == bst_pkg::ST_CAP_DR),
        .shift_i   (tck_rise && sel_bscan && q.state == bst_pkg::ST_SH_DR),
        .update_i  (tck_fall && sel_bscan && q.state == bst_pkg::ST_UPD_DR),
        .tdi_i     (q.tdi_s2),
        .par_i     (ch_par),
        .so_o      (ch_so),
        .upd_o     (ch_upd)
    );

    always_comb begin
        d = q;
        d.tck_s1    = tck_i;
        d.tck_s2    = q.tck_s1;
        d.tck_s3    = q.tck_s2;
        d.tms_s1    = tms_i;
        d.tms_s2    = q.tms_s1;
        d.tdi_s1    = tdi_i;
        d.tdi_s2    = q.tdi_s1;
        d.trst_n_s1 = trst_n_i;
        d.trst_n_s2 = q.trst_n_s1;
        d.pad_s1    = pad_in_i;
        d.pad_s2    = q.pad_s1;
        d.core_in   = q.pad_s2;

        if (tck_rise) begin
            d.state = next_state(q.state, q.tms_s2);
            case (q.state)
                bst_pkg::ST_CAP_IR: d.ir_sh = bst_pkg::IR_CAPTURE;
                bst_pkg::ST_SH_IR:  d.ir_sh = {q.tdi_s2, q.ir_sh[bst_pkg::IR_W-1:1]};
                bst_pkg::ST_CAP_DR: begin
                    d.byp   = 1'b0;
                    d.id_sh = bst_pkg::ID_VALUE;
                end
                bst_pkg::ST_SH_DR: begin
                    d.byp   = q.tdi_s2;
                    d.id_sh = {q.tdi_s2, q.id_sh[bst_pkg::ID_W-1:1]};
                end
                default: ;
            endcase
        end

        // Data out moves only on the falling edge so the tester samples a settled bit
        if (tck_fall) begin
            if (q.state == bst_pkg::ST_UPD_IR) begin
                d.ir = q.ir_sh;
            end
            d.tdo_oe = in_shift;
            if (q.state == bst_pkg::ST_SH_IR) begin
                d.tdo = q.ir_sh[0];
            end else if (q.state == bst_pkg::ST_SH_DR) begin
                if (sel_bscan) begin
                    d.tdo = ch_so;
                end else if (mode == bst_pkg::MD_IDCODE) begin
                    d.tdo = q.id_sh[0];
                end else begin
                    d.tdo = q.byp;
                end
            end
        end

        if (q.state == bst_pkg::ST_TLR) begin
            d.ir = bst_pkg::IR_IDCODE;
        end

        // Test reset acts without any test-clock edge
        if (!q.trst_n_s2) begin
            d.state  = bst_pkg::ST_TLR;
            d.ir     = bst_pkg::IR_IDCODE;
            d.tdo_oe = 1'b0;
        end

        if (mode == bst_pkg::MD_HIGHZ) begin
            d.pad_out = core_out_i;
            d.pad_oe  = '0;
        end else if (pins_from_chain) begin
            d.pad_out = {ch_upd[bst_pkg::CH_BI_LO +: bst_pkg::N_BI],
                         ch_upd[bst_pkg::CH_OUT_LO +: bst_pkg::N_OUT]};
            d.pad_oe  = {ch_upd[bst_pkg::CH_CTL_LO +: bst_pkg::N_BI], {bst_pkg::N_OUT{1'b1}}};
        end else begin
            d.pad_out = core_out_i;
            d.pad_oe  = {core_oe_i, {bst_pkg::N_OUT{1'b1}}};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            q    <= '0;
            q.ir <= bst_pkg::IR_IDCODE;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign tdo_o     = q.tdo;
    assign tdo_oe_o  = q.tdo_oe;
    assign pad_out_o = q.pad_out;
    assign pad_oe_o  = q.pad_oe;
    assign core_in_o = q.core_in;
    assign ir_o      = q.ir;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);

    a_por_reset_state: assert property (disable iff (1'b0) srst_i |=> q.state == bst_pkg::ST_TLR && q.ir == bst_pkg::IR_IDCODE)
        else $error("power-on reset did not reach test-logic-reset");

    a_trst_forces_tlr: assert property (!q.trst_n_s2 && ce_i |=> q.state == bst_pkg::ST_TLR && q.ir == bst_pkg::IR_IDCODE)
        else $error("test reset did not force test-logic-reset");

    a_tlr_leaves_rti: assert property (q.trst_n_s2 && ce_i && tck_rise && q.state == bst_pkg::ST_TLR && !q.tms_s2
                                       |=> q.state == bst_pkg::ST_RTI)
        else $error("controller left test-logic-reset wrongly");

    a_state_holds_idle: assert property (ce_i && !tck_rise && q.trst_n_s2 |=> q.state == $past(q.state))
        else $error("controller moved without a test-clock edge");

    a_bypass_one_bit: assert property (ce_i && tck_rise && q.state == bst_pkg::ST_SH_DR && mode == bst_pkg::MD_BYPASS
                                       |=> q.byp == $past(q.tdi_s2))
        else $error("bypass stage did not take data in");

    a_undefined_bypass: assert property (q.ir == 5'h13 |-> mode == bst_pkg::MD_BYPASS)
        else $error("undefined code not treated as bypass");

    a_highz_release: assert property (ce_i && mode == bst_pkg::MD_HIGHZ |=> pad_oe_o == '0)
        else $error("pins driven under high-impedance instruction");

    a_clamp_from_chain: assert property (ce_i && mode == bst_pkg::MD_CLAMP |=> pad_out_o[bst_pkg::N_OUT-1:0]
                                         == $past(ch_upd[bst_pkg::CH_OUT_LO +: bst_pkg::N_OUT]))
        else $error("clamp not driving from boundary contents");

    a_idcode_capture: assert property (ce_i && tck_rise && q.state == bst_pkg::ST_CAP_DR
                                       |=> q.id_sh == bst_pkg::ID_VALUE && q.id_sh[0])
        else $error("identification value not captured");

    a_ir_capture_01: assert property (ce_i && tck_rise && q.state == bst_pkg::ST_CAP_IR && q.trst_n_s2
                                      |=> q.ir_sh[1:0] == 2'b01)
        else $error("instruction capture pattern wrong");

    a_tdo_released: assert property (ce_i && tck_fall && !in_shift |=> !tdo_oe_o ##1 !tdo_oe_o || tck_fall)
        else $error("data out driven outside shift states");

    a_ir_update_load: assert property (ce_i && tck_fall && q.state == bst_pkg::ST_UPD_IR && q.trst_n_s2
                                       |=> ir_o == $past(q.ir_sh))
        else $error("instruction not loaded at update");

    a_tdo_oe_shift: assert property (ce_i && tck_fall && in_shift && q.trst_n_s2 |=> tdo_oe_o)
        else $error("data out not driven in shift state");

    a_tdo_ir_bit: assert property (ce_i && tck_fall && q.state == bst_pkg::ST_SH_IR
                                   |=> tdo_o == $past(q.ir_sh[0]))
        else $error("instruction bit not on data out");

    a_tdo_id_bit: assert property (ce_i && tck_fall && q.state == bst_pkg::ST_SH_DR && mode == bst_pkg::MD_IDCODE
                                   |=> tdo_o == $past(q.id_sh[0]))
        else $error("identification bit not on data out");

    a_tdo_bypass_bit: assert property (ce_i && tck_fall && q.state == bst_pkg::ST_SH_DR
                                       && mode == bst_pkg::MD_BYPASS |=> tdo_o == $past(q.byp))
        else $error("bypass bit not on data out");

    a_tdo_chain_bit: assert property (ce_i && tck_fall && q.state == bst_pkg::ST_SH_DR && sel_bscan
                                      |=> tdo_o == $past(ch_so))
        else $error("boundary bit not on data out");

    a_bypass_capture: assert property (ce_i && tck_rise && q.state == bst_pkg::ST_CAP_DR |=> !q.byp)
        else $error("bypass stage did not capture zero");

    a_ir_shift_path: assert property (ce_i && tck_rise && q.state == bst_pkg::ST_SH_IR
                                      |=> q.ir_sh == {$past(q.tdi_s2), $past(q.ir_sh[bst_pkg::IR_W-1:1])})
        else $error("instruction shift not least bit first");

    a_sample_pins_func: assert property (ce_i && mode == bst_pkg::MD_SAMPLE
                                         |=> pad_out_o == $past(core_out_i)
                                         && pad_oe_o == $past({core_oe_i, {bst_pkg::N_OUT{1'b1}}}))
        else $error("sample disturbed the pins");

    a_extest_pins: assert property (ce_i && mode == bst_pkg::MD_EXTEST
                                    |=> pad_out_o == $past({ch_upd[bst_pkg::CH_BI_LO +: bst_pkg::N_BI],
                                                            ch_upd[bst_pkg::CH_OUT_LO +: bst_pkg::N_OUT]}))
        else $error("extest not driving from boundary contents");

    a_clamp_oe: assert property (ce_i && mode == bst_pkg::MD_CLAMP
                                 |=> pad_oe_o[bst_pkg::N_PIN_OUT-1:bst_pkg::N_OUT]
                                 == $past(ch_upd[bst_pkg::CH_CTL_LO +: bst_pkg::N_BI]))
        else $error("clamp enables not from control cells");

    a_core_in_free: assert property (ce_i |=> core_in_o == $past(q.pad_s2))
        else $error("core input path disturbed by test logic");

    a_tlr_loads_id: assert property (ce_i && q.state == bst_pkg::ST_TLR |=> ir_o == bst_pkg::IR_IDCODE)
        else $error("test-logic-reset did not load identification");

    // Frozen state must not drift while the enable is low
    a_ce_freeze: assert property (!ce_i |=> q == $past(q))
        else $error("state changed with clock enable low");

    c_ir_update: cover property (ce_i && tck_fall && q.state == bst_pkg::ST_UPD_IR);
    c_extest_update: cover property (ce_i && tck_fall && q.state == bst_pkg::ST_UPD_DR && mode == bst_pkg::MD_EXTEST);
    c_idcode_shift: cover property (ce_i && tck_fall && q.state == bst_pkg::ST_SH_DR && mode == bst_pkg::MD_IDCODE);
    c_trst_hit: cover property (!q.trst_n_s2 && q.state == bst_pkg::ST_SH_DR);
endmodule // bst_tap
`default_nettype wire

// *** dv/bst_jtag_master.sv ***
// Scan master model: drives the test port pins, samples test data out.
// Assumes the test clock stands low between frames and nothing else drives these pins.
`timescale 1ns/1ns
`default_nettype none
module bst_jtag_master (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    output logic      trst_n_o,
    input  wire logic tdo_i
);
    initial begin
        tck_o    = 1'b0;
        tms_o    = 1'b1;
        tdi_o    = 1'b0;
        trst_n_o = 1'b1;
    end

    // One 80 ns test clock period; data out taken at the rising edge
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #40;
        tck_o = 1'b1;
        tdo = tdo_i;
        #40;
        tck_o = 1'b0;
    endtask

    // Five ones reach Test-Logic-Reset from anywhere, then park in Run-Test/Idle
    task automatic goto_idle();
        logic t;
        repeat (5) tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
    endtask

    // Full scan from Run-Test/Idle back to Run-Test/Idle, LSB first
    task automatic scan(input logic ir, input logic [63:0] din, input int n, output logic [63:0] dout);
        logic t;
        dout = 64'h0;
        tick(1'b1, 1'b0, t);
        if (ir) tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
        tick(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], t);
            dout[i] = t;
        end
        tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
        // Released data line does not keep its last value
        tdi_o = ~tdi_o;
    endtask

    // Test reset needs no test clock edge
    task automatic pulse_trst();
        trst_n_o = 1'b0;
        #100;
        trst_n_o = 1'b1;
        #100;
    endtask
endmodule // bst_jtag_master
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the boundary-scan test access port.
// Assumes the scan master model is the only driver of the test pins.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        mclk, srst, tck, tms, tdi, trst_n, tdo, tdo_oe;
    logic [3:0]  pad_in, pad_out, pad_oe, core_out, core_in;
    logic [1:0]  core_oe;
    logic [4:0]  ir;
    logic [63:0] d;
    int          errors;
    int          comparisons;
    wire logic   tdo_w;

    // Data out floats while not enabled
    assign tdo_w = tdo_oe ? tdo : 1'bz;

    bst_tap u_bst_tap (
        .mclk_i(mclk), .srst_i(srst), .ce_i(1'b1), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
        .core_out_i(core_out), .core_oe_i(core_oe), .core_in_o(core_in), .ir_o(ir)
    );

    bst_jtag_master u_bst_jtag_master (
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo_w)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic mwait(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk_func();
        chk("pad_out", {60'h0, core_out}, {60'h0, pad_out});
        chk("pad_oe", {60'h0, core_oe, 2'b11}, {60'h0, pad_oe});
        chk("core_in", {60'h0, pad_in}, {60'h0, core_in});
        chk("tdo_oe", 64'h0, {63'h0, tdo_oe});
    endtask

    task automatic load_ir(input logic [4:0] code);
        u_bst_jtag_master.scan(1'b1, {59'h0, code}, 5, d);
        mwait(2);
        chk("ir capture", {59'h0, bst_pkg::IR_CAPTURE}, d);
        chk("ir", {59'h0, code}, {59'h0, ir});
    endtask

    task automatic chk_bypass();
        u_bst_jtag_master.scan(1'b0, 64'hB4, 8, d);
        chk("bypass path", 64'h68, d);
    endtask

    task automatic do_reset();
        @(posedge mclk);
        srst <= 1'b1;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        mwait(8);
        chk("ir after reset", {59'h0, bst_pkg::IR_IDCODE}, {59'h0, ir});
        chk_func();
        u_bst_jtag_master.goto_idle();
    endtask

    task automatic t_idcode();
        u_bst_jtag_master.scan(1'b0, 64'h0, 32, d);
        chk("idcode", {32'h0, bst_pkg::ID_VALUE}, d);
        chk("idcode bit0", 64'h1, {63'h0, d[0]});
        $display("test idcode done");
    endtask

    task automatic t_bypass();
        logic [4:0] codes [5] = '{bst_pkg::IR_BYPASS, 5'h02, 5'h09, 5'h0A, 5'h13};
        foreach (codes[k]) begin
            load_ir(codes[k]);
            chk_bypass();
            chk_func();
        end
        u_bst_jtag_master.goto_idle();
        mwait(2);
        chk("ir after tms reset", {59'h0, bst_pkg::IR_IDCODE}, {59'h0, ir});
        $display("test bypass done");
    endtask

    task automatic t_boundary();
        logic [7:0] cap;
        cap = {core_oe, pad_in[3:2], core_out[1:0], pad_in[1:0]};
        load_ir(bst_pkg::IR_SAMPLE);
        u_bst_jtag_master.scan(1'b0, 64'h5C, 8, d);
        mwait(2);
        chk("sample capture", {56'h0, cap}, d);
        chk_func();
        load_ir(bst_pkg::IR_EXTEST);
        chk("extest out", 64'h7, {60'h0, pad_out});
        chk("extest oe", 64'h7, {60'h0, pad_oe});
        u_bst_jtag_master.scan(1'b0, 64'hA3, 8, d);
        mwait(2);
        chk("extest capture", {56'h0, cap}, d);
        chk("extest out 2", 64'h8, {60'h0, pad_out});
        chk("extest oe 2", 64'hB, {60'h0, pad_oe});
        chk("core_in", {60'h0, pad_in}, {60'h0, core_in});
        load_ir(bst_pkg::IR_CLAMP);
        chk_bypass();
        chk("clamp out", 64'h8, {60'h0, pad_out});
        chk("clamp oe", 64'hB, {60'h0, pad_oe});
        load_ir(bst_pkg::IR_HIGHZ);
        chk_bypass();
        chk("highz oe", 64'h0, {60'h0, pad_oe});
        chk("tdo_oe", 64'h0, {63'h0, tdo_oe});
        $display("test boundary done");
    endtask

    task automatic t_resets();
        load_ir(bst_pkg::IR_EXTEST);
        do_reset();
        load_ir(bst_pkg::IR_BYPASS);
        u_bst_jtag_master.pulse_trst();
        chk("ir after trst", {59'h0, bst_pkg::IR_IDCODE}, {59'h0, ir});
        chk_func();
        u_bst_jtag_master.goto_idle();
        t_idcode();
        $display("test resets done");
    endtask

    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        srst        = 1'b1;
        pad_in      = 4'h9;
        core_out    = 4'h6;
        core_oe     = 2'b10;
        errors      = 0;
        comparisons = 0;
        do_reset();
        t_idcode();
        t_bypass();
        t_boundary();
        t_resets();
        stop_test();
    end

    // Whole run is well under 100 us of test clock traffic
    initial begin
        #400000;
        errors++;
        $display("watchdog expired");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
